// file: shared/qsp_defs.vh
// Purpose: Constants for the serial peripheral controller core
// Assumes: Included by the core design file by bare name
// Notes: Build options are defaults for the top-level parameters
//
// Overview of operation
// - Slave selected while not enabled raises a sticky slave mode-fault flag.
// - Manual select with enabled master drives select vector steadily between elements.
// - Inhibit input blocks master transfers in every master mode.
// - No write-collision flag; transmit data is buffered, not transparent.
// - Interrupt enable lives elsewhere; the freed control bit selects loopback.
// - Build option adds transmit and receive FIFOs together, full duplex only.
// - Transfer width parameter selects 8, 16 or 32 bit elements.
// - Clock divider is a build parameter: 2, 4, 16, 32 or multiples of 16.
// - Ratio 2 master captures input midway, at the following trailing edge.
// - Master changes outgoing data on every trailing serial clock edge, falling when idle low.
// - Slave captures one cycle after rise, changes data two cycles after fall.
// - Ratio 16 gives about seven clock cycles setup before sampling edge.
// - Execute-in-place status bits appear five cycles after their event.
// - Data registers hold WIDTH bits, 8 with the default build.
// - Execute-in-place memory port accepts reads only; writes flag an error.
// - Execute-in-place with clock mode other than 00 or 11 flags, refuses.
// - Execute-in-place status is read-only; its sticky fault bits clear when read.
`ifndef QSP_DEFS_VH
`define QSP_DEFS_VH

`define QSP_WIDTH 8
`define QSP_RATIO 16
`define QSP_FIFO_DEPTH 16
`define QSP_USE_FIFO 1
`define QSP_NSEL 1
`define QSP_DATA_BITS 8
`define QSP_EIP_DLY 5

`define QSP_ST_RX_EMPTY 0
`define QSP_ST_RX_FULL 1
`define QSP_ST_MMODF 2
`define QSP_ST_CPERR 3
`define QSP_ST_BUSERR 4
`define QSP_ST_W 5
`define QSP_ST_RST 5'h01
`define QSP_ST_STICKY 5'h1c

`define QSP_S_IDLE 2'h0
`define QSP_S_MSHIFT 2'h1
`define QSP_S_SSHIFT 2'h2

`endif

// file: rtl/qsp_fifo.v
// Purpose: Small first-in first-out store of flip-flops
// Assumes: Writes when full and reads when empty are ignored
// Notes: Show-ahead read data, registered occupancy count
`timescale 1ns/10ps
module qsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_in,                // Core clock
  input wire sys_rst_in,            // Synchronous reset
  input wire wr_in,                 // Write strobe
  input wire [WIDTH-1:0] data_in,   // Write data
  input wire rd_in,                 // Read strobe
  output wire [WIDTH-1:0] data_out, // Head element
  output reg full_out,              // No room left
  output reg empty_out,             // Nothing stored
  output reg [AW:0] count_out       // Occupancy
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  wire do_wr;
  wire do_rd;
  wire [AW:0] cnt_d;

  assign do_wr = wr_in & ~full_out;
  assign do_rd = rd_in & ~empty_out;
  assign cnt_d = count_out + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
  assign data_out = mem_q[rd_ptr_q];

  // ----------------------------------------
  // Pointers and flags
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_out <= {(AW+1){1'b0}};
      full_out <= 1'b0;
      empty_out <= 1'b1;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      count_out <= cnt_d;
      full_out <= (cnt_d == DEPTH[AW:0]);
      empty_out <= (cnt_d == {(AW+1){1'b0}});
    end
  end

  always @(posedge clk_in) begin
    if (do_wr) begin
      mem_q[wr_ptr_q] <= data_in;
    end
  end
endmodule

// file: rtl/qsp_core.v
// Purpose: Serial peripheral controller core, master or slave
// Assumes: All pin inputs synchronous to clk_in; control bits are plain ports
// Notes: Data registers hold WIDTH bits; execute-in-place checks only
`timescale 1ns/10ps
`include "qsp_defs.vh"
module qsp_core #(
  parameter WIDTH = `QSP_WIDTH,
  parameter RATIO = `QSP_RATIO,
  parameter USE_FIFO = `QSP_USE_FIFO,
  parameter FIFO_DEPTH = `QSP_FIFO_DEPTH,
  parameter NSEL = `QSP_NSEL
) (
  input wire clk_in,                  // 125 MHz core clock
  input wire sys_rst_in,              // Synchronous reset, high
  input wire enable_in,               // Core enable
  input wire master_in,               // 1 master, 0 slave
  input wire cpol_in,                 // Clock idle level
  input wire cpha_in,                 // Clock phase, checked in eip mode
  input wire manual_sel_in,           // Manual select vector control
  input wire inhibit_in,              // Master transfer inhibit
  input wire loopback_in,             // Local master loopback
  input wire [NSEL-1:0] select_vector_reg_in, // Select vector, bit high selects
  input wire flag_clr_in,             // Clear sticky overrun and slave fault flags, pulse
  input wire tx_wr_in,                // Transmit data write, pulse
  input wire [WIDTH-1:0] tx_data_in,  // Transmit data
  input wire rx_rd_in,                // Receive data read, pulse
  output reg [WIDTH-1:0] receive_data_reg_out, // Receive head
  output reg tx_full_out,             // Transmit store full
  output reg rx_empty_out,            // Receive store empty
  output reg [5:0] tx_occ_out,        // Transmit occupancy
  output reg [5:0] rx_occ_out,        // Receive occupancy
  output reg rx_overrun_out,          // Sticky receive overrun
  output reg slave_modf_out,          // Sticky slave mode fault
  output reg busy_out,                // Transfer in progress
  input wire sck_in,                  // Serial clock pin input
  output reg sck_out,                 // Serial clock pin output
  output reg sck_oe_out,              // Serial clock drive enable
  input wire io0_in,                  // Data pin 0 input (slave in)
  output reg io0_out,                 // Data pin 0 output
  output reg io0_oe_out,              // Data pin 0 drive enable
  input wire io1_in,                  // Data pin 1 input (master in)
  output reg io1_out,                 // Data pin 1 output
  output reg io1_oe_out,              // Data pin 1 drive enable
  input wire sel_n_in,                // Select input, low active
  output reg [NSEL-1:0] sel_n_out,    // Select outputs, low active
  input wire execute_in_place_mode_in, // Execute-in-place mode
  input wire mem_rd_req_in,           // Memory port read request, pulse
  input wire mem_wr_req_in,           // Memory port write request, pulse
  output reg mem_rd_ack_out,          // Read request accepted, pulse
  output reg mem_err_out,             // Request refused, pulse
  input wire eip_status_rd_in,        // Status read strobe, pulse
  output reg [`QSP_ST_W-1:0] eip_status_reg_out // Execute-in-place status
);
  localparam DEPTH = (USE_FIFO != 0) ? FIFO_DEPTH : 1;
  localparam HALF = RATIO / 2;
  localparam CW = 11;
  localparam [CW-1:0] HALF_M1 = HALF - 1;
  localparam [5:0] BITS = WIDTH;

  // ----------------------------------------
  // Transmit and receive stores, always paired
  // ----------------------------------------
  wire [WIDTH-1:0] txf_data;
  wire [WIDTH-1:0] rxf_data;
  wire txf_full;
  wire txf_empty;
  wire rxf_full;
  wire rxf_empty;
  wire [4:0] txf_cnt;
  wire [4:0] rxf_cnt;
  reg tx_pop;
  reg rx_push;
  reg [WIDTH-1:0] rx_word;

  // Transmit store feeds the shifter, never the pin directly
  qsp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(4)) u_txf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(tx_wr_in),
    .data_in(tx_data_in),
    .rd_in(tx_pop),
    .data_out(txf_data),
    .full_out(txf_full),
    .empty_out(txf_empty),
    .count_out(txf_cnt)
  );

  qsp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(4)) u_rxf (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_in(rx_push),
    .data_in(rx_word),
    .rd_in(rx_rd_in),
    .data_out(rxf_data),
    .full_out(rxf_full),
    .empty_out(rxf_empty),
    .count_out(rxf_cnt)
  );

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  reg [1:0] state_q;
  reg [CW-1:0] div_q;
  reg [WIDTH-1:0] tx_sh_q;
  reg [WIDTH-1:0] rx_sh_q;
  reg [5:0] bit_q;
  reg sck_prev_q;
  reg mid_bit_q;
  wire tick;
  wire m_ok;
  wire s_sel;
  wire s_rise;
  wire s_fall;
  wire in_bit;

  assign tick = (div_q == HALF_M1);
  assign m_ok = enable_in & master_in & ~inhibit_in;
  assign s_sel = enable_in & ~master_in & ~sel_n_in;
  // Edges seen one clock late from registered previous level
  assign s_rise = (sck_in ^ cpol_in) & ~(sck_prev_q ^ cpol_in);
  assign s_fall = ~(sck_in ^ cpol_in) & (sck_prev_q ^ cpol_in);
  assign in_bit = loopback_in ? tx_sh_q[WIDTH-1] : io1_in;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= `QSP_S_IDLE;
      div_q <= {CW{1'b0}};
      tx_sh_q <= {WIDTH{1'b0}};
      rx_sh_q <= {WIDTH{1'b0}};
      rx_word <= {WIDTH{1'b0}};
      bit_q <= 6'h00;
      sck_prev_q <= sck_in;
      mid_bit_q <= 1'b0;
      sck_out <= 1'b0;
      tx_pop <= 1'b0;
      rx_push <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      rx_push <= 1'b0;
      sck_prev_q <= sck_in;
      case (state_q)
        `QSP_S_IDLE: begin
          sck_out <= cpol_in;
          div_q <= {CW{1'b0}};
          bit_q <= 6'h00;
          if (m_ok & ~txf_empty & ~tx_pop & ~execute_in_place_mode_in) begin
            tx_sh_q <= txf_data;
            tx_pop <= 1'b1;
            state_q <= `QSP_S_MSHIFT;
          end else if (s_sel & ~execute_in_place_mode_in) begin
            tx_sh_q <= txf_empty ? {WIDTH{1'b0}} : txf_data;
            tx_pop <= ~txf_empty & ~tx_pop;
            state_q <= `QSP_S_SSHIFT;
          end
        end
        `QSP_S_MSHIFT: begin
          // Inhibit aborts the element; clock parks at idle
          if (~m_ok) begin
            state_q <= `QSP_S_IDLE;
          end else begin
            div_q <= tick ? {CW{1'b0}} : div_q + 1'b1;
            if (tick) begin
              sck_out <= ~sck_out;
              if (sck_out == cpol_in) begin
                // Leading edge (rising when idle low)
                if (RATIO == 2) begin
                  mid_bit_q <= 1'b1;
                end else begin
                  rx_sh_q <= {rx_sh_q[WIDTH-2:0], in_bit};
                end
              end else begin
                // Trailing edge (falling when idle low): capture if deferred, then shift
                if (mid_bit_q) begin
                  rx_sh_q <= {rx_sh_q[WIDTH-2:0], in_bit};
                  mid_bit_q <= 1'b0;
                end
                tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
                bit_q <= bit_q + 6'h01;
                if (bit_q == BITS - 6'h01) begin
                  rx_word <= mid_bit_q ? {rx_sh_q[WIDTH-2:0], in_bit} : rx_sh_q;
                  rx_push <= 1'b1;
                  state_q <= `QSP_S_IDLE;
                end
              end
            end
          end
        end
        `QSP_S_SSHIFT: begin
          if (~s_sel) begin
            state_q <= `QSP_S_IDLE;
          end else begin
            if (s_rise) begin
              rx_sh_q <= {rx_sh_q[WIDTH-2:0], io0_in};
              if (bit_q == BITS - 6'h01) begin
                rx_word <= {rx_sh_q[WIDTH-2:0], io0_in};
                rx_push <= 1'b1;
              end
            end
            if (s_fall) begin
              bit_q <= (bit_q == BITS - 6'h01) ? 6'h00 : bit_q + 6'h01;
              if (bit_q == BITS - 6'h01) begin
                tx_sh_q <= txf_empty ? {WIDTH{1'b0}} : txf_data;
                tx_pop <= ~txf_empty;
              end else begin
                tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
              end
            end
          end
        end
        default: begin
          state_q <= `QSP_S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pins, selects, flags and user outputs
  // ----------------------------------------
  wire m_en;
  assign m_en = enable_in & master_in;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sck_oe_out <= 1'b0;
      io0_out <= 1'b0;
      io0_oe_out <= 1'b0;
      io1_out <= 1'b0;
      io1_oe_out <= 1'b0;
      sel_n_out <= {NSEL{1'b1}};
      slave_modf_out <= 1'b0;
      rx_overrun_out <= 1'b0;
      receive_data_reg_out <= {WIDTH{1'b0}};
      tx_full_out <= 1'b0;
      rx_empty_out <= 1'b1;
      tx_occ_out <= 6'h00;
      rx_occ_out <= 6'h00;
      busy_out <= 1'b0;
    end else begin
      sck_oe_out <= m_en;
      io0_oe_out <= m_en & ~loopback_in;
      io0_out <= tx_sh_q[WIDTH-1];
      io1_oe_out <= (state_q == `QSP_S_SSHIFT);
      io1_out <= tx_sh_q[WIDTH-1];
      if (m_en & manual_sel_in) begin
        sel_n_out <= ~select_vector_reg_in;
      end else if (state_q == `QSP_S_MSHIFT) begin
        sel_n_out <= ~select_vector_reg_in;
      end else begin
        sel_n_out <= {NSEL{1'b1}};
      end
      // Set wins over clear
      slave_modf_out <= (~master_in & ~enable_in & ~sel_n_in) |
                        (slave_modf_out & ~flag_clr_in);
      rx_overrun_out <= (rx_push & rxf_full) | (rx_overrun_out & ~flag_clr_in);
      receive_data_reg_out <= rxf_data;
      tx_full_out <= txf_full;
      rx_empty_out <= rxf_empty;
      tx_occ_out <= {1'b0, txf_cnt};
      rx_occ_out <= {1'b0, rxf_cnt};
      busy_out <= (state_q != `QSP_S_IDLE);
    end
  end

  // ----------------------------------------
  // Execute-in-place request check and status
  // ----------------------------------------
  reg [`QSP_ST_W-1:0] ev_pipe_q [0:`QSP_EIP_DLY-2];
  reg [`QSP_ST_W-1:0] ev_now;
  wire cp_bad;
  integer i;
  assign cp_bad = cpol_in ^ cpha_in;

  always @* begin
    ev_now = {`QSP_ST_W{1'b0}};
    ev_now[`QSP_ST_BUSERR] = execute_in_place_mode_in & mem_wr_req_in;
    ev_now[`QSP_ST_CPERR] = execute_in_place_mode_in & mem_rd_req_in & cp_bad;
    ev_now[`QSP_ST_MMODF] = execute_in_place_mode_in & sel_n_in;
    ev_now[`QSP_ST_RX_FULL] = rxf_full;
    ev_now[`QSP_ST_RX_EMPTY] = rxf_empty;
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (i = 0; i < `QSP_EIP_DLY - 1; i = i + 1) begin
        ev_pipe_q[i] <= `QSP_ST_RST;
      end
      eip_status_reg_out <= `QSP_ST_RST;
      mem_rd_ack_out <= 1'b0;
      mem_err_out <= 1'b0;
    end else begin
      ev_pipe_q[0] <= ev_now;
      for (i = 1; i < `QSP_EIP_DLY - 1; i = i + 1) begin
        ev_pipe_q[i] <= ev_pipe_q[i-1];
      end
      // Sticky bits clear on read, late set wins; writes never alter it
      eip_status_reg_out <= (ev_pipe_q[`QSP_EIP_DLY-2] & `QSP_ST_STICKY) |
                            (ev_pipe_q[`QSP_EIP_DLY-2] & ~`QSP_ST_STICKY) |
                            (eip_status_reg_out & `QSP_ST_STICKY &
                             {`QSP_ST_W{~eip_status_rd_in}});
      mem_rd_ack_out <= execute_in_place_mode_in & mem_rd_req_in & ~cp_bad;
      mem_err_out <= execute_in_place_mode_in &
                     (mem_wr_req_in | (mem_rd_req_in & cp_bad));
    end
  end
endmodule

// file: tb/qsp_core_properties.sv
// Purpose: Port checks for the controller core
// Assumes: Bound to every qsp_core instance
// Notes: Latencies follow the core hand-over timing
`timescale 1ns/10ps
module qsp_core_props #(
  parameter NSEL = 1
) (
  input wire clk_in,                   // Clock
  input wire sys_rst_in,               // Reset
  input wire enable_in,                // Enable
  input wire master_in,                // Master mode
  input wire cpol_in,                  // Idle level
  input wire cpha_in,                  // Phase
  input wire manual_sel_in,            // Manual select
  input wire inhibit_in,               // Inhibit
  input wire [NSEL-1:0] select_vector_reg_in, // Vector
  input wire sel_n_in,                 // Select in
  input wire slave_modf_out,           // Slave fault
  input wire sck_out,                  // Serial clock
  input wire [NSEL-1:0] sel_n_out,     // Selects
  input wire execute_in_place_mode_in, // Eip mode
  input wire mem_rd_req_in,            // Read req
  input wire mem_wr_req_in,            // Write req
  input wire mem_rd_ack_out,           // Read ack
  input wire mem_err_out,              // Refused
  input wire eip_status_rd_in,         // Status read
  input wire [4:0] eip_status_reg_out  // Status
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  slave_modf_a: assert property (
    !enable_in && !master_in && !sel_n_in |=> slave_modf_out)
    else $error("slave fault flag not raised");
  inhibit_idle_a: assert property (
    (inhibit_in && master_in && $stable(cpol_in))[*4] |-> sck_out == cpol_in)
    else $error("serial clock left idle while inhibited");
  manual_sel_a: assert property (
    (enable_in && master_in && manual_sel_in && !execute_in_place_mode_in
     && $stable(select_vector_reg_in))[*3] |-> sel_n_out == ~select_vector_reg_in)
    else $error("manual select vector not driven");
  eip_wr_err_a: assert property (
    execute_in_place_mode_in && mem_wr_req_in |=> mem_err_out && !mem_rd_ack_out)
    else $error("memory write not refused");
  eip_mode_err_a: assert property (
    execute_in_place_mode_in && mem_rd_req_in && cpol_in != cpha_in
    |=> mem_err_out && !mem_rd_ack_out)
    else $error("bad clock mode read not refused");
  eip_rd_ack_a: assert property (
    execute_in_place_mode_in && mem_rd_req_in && !mem_wr_req_in && cpol_in == cpha_in
    |=> mem_rd_ack_out && !mem_err_out)
    else $error("memory read not accepted");
  status_delay_a: assert property (
    execute_in_place_mode_in && mem_wr_req_in |-> ##5 eip_status_reg_out[4])
    else $error("bus error status late");
  status_clear_a: assert property (
    (!execute_in_place_mode_in)[*6] ##0 eip_status_rd_in |=> eip_status_reg_out[4:2] == 3'h0)
    else $error("status not cleared by read");
endmodule
bind qsp_core qsp_core_props #(.NSEL(NSEL)) qsp_core_props_inst (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .enable_in(enable_in), .master_in(master_in),
  .cpol_in(cpol_in), .cpha_in(cpha_in), .manual_sel_in(manual_sel_in),
  .inhibit_in(inhibit_in), .select_vector_reg_in(select_vector_reg_in),
  .sel_n_in(sel_n_in), .slave_modf_out(slave_modf_out), .sck_out(sck_out),
  .sel_n_out(sel_n_out), .execute_in_place_mode_in(execute_in_place_mode_in),
  .mem_rd_req_in(mem_rd_req_in), .mem_wr_req_in(mem_wr_req_in),
  .mem_rd_ack_out(mem_rd_ack_out), .mem_err_out(mem_err_out),
  .eip_status_rd_in(eip_status_rd_in), .eip_status_reg_out(eip_status_reg_out));

// file: tb/qsp_flash_model.sv
// Purpose: Serial slave device on the far side of the link
// Assumes: Clock idle low, sample on rise, shift on fall
// Notes: Released output shows the inverse of its last value
`timescale 1ns/10ps
module qsp_flash_model (
  input wire sck_in,         // Serial clock
  input wire sel_n_in,       // Select, low active
  input wire mosi_in,        // Data from master
  input wire [7:0] reply_in, // Reply element
  output reg miso_out,       // Data to master
  output reg [7:0] got_out   // Last bits received
);
  reg [7:0] sh_q;
  initial begin
    miso_out = 1'h0;
    sh_q = 8'h00;
    got_out = 8'h00;
  end
  // Only one device selected at a time
  always @(negedge sel_n_in) begin
    sh_q = reply_in;
    miso_out = reply_in[7];
  end
  always @(posedge sel_n_in) miso_out = ~miso_out;
  always @(posedge sck_in) if (!sel_n_in) got_out = {got_out[6:0], mosi_in};
  always @(negedge sck_in) begin
    if (!sel_n_in) begin
      sh_q = {sh_q[6:0], 1'h0};
      miso_out = sh_q[7];
    end
  end
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the controller core
// Assumes: Inputs change at falling clock edges
// Notes: Default 8-bit elements and clock ratio 16
`timescale 1ns/10ps
module testbench;
  reg clk_in, sys_rst_in = 1'h1, enable_in = 1'h0, master_in = 1'h1, cpha_in = 1'h0;
  reg manual_sel_in = 1'h0, inhibit_in = 1'h0, loopback_in = 1'h0, flag_clr_in = 1'h0;
  reg tx_wr_in = 1'h0, rx_rd_in = 1'h0, sel_n_in = 1'h1, eip = 1'h0, mem_rd = 1'h0;
  reg mem_wr = 1'h0, st_rd = 1'h0, bad;
  reg cpol_in = 1'h0, s_sck = 1'h0, s_mosi = 1'h0;
  reg [7:0] miso_word = 8'h00, s_tx = 8'h69;
  reg [0:0] sel_vec = 1'h1;
  reg [7:0] tx_data_in = 8'h00, reply = 8'h3c;
  wire [7:0] rx_data, got;
  wire [5:0] rx_occ, tx_occ;
  wire [4:0] st;
  wire [0:0] sel_n_out;
  wire rx_empty, modf, busy, sck, io0, io1, mem_ack, mem_err;
  wire s_miso, sck_oe, io0_oe, io1_oe;
  wire sck_pin = master_in ? sck : s_sck;
  wire mosi_pin = master_in ? io0 : s_mosi;
  integer mismatches = 0, n_checks = 0, i;
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end
  qsp_core qsp_core_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .enable_in(enable_in),
    .master_in(master_in), .cpol_in(cpol_in), .cpha_in(cpha_in), .manual_sel_in(manual_sel_in),
    .inhibit_in(inhibit_in), .loopback_in(loopback_in), .select_vector_reg_in(sel_vec),
    .flag_clr_in(flag_clr_in), .tx_wr_in(tx_wr_in), .tx_data_in(tx_data_in),
    .rx_rd_in(rx_rd_in), .receive_data_reg_out(rx_data), .tx_full_out(), .rx_empty_out(rx_empty),
    .tx_occ_out(tx_occ), .rx_occ_out(rx_occ), .rx_overrun_out(), .slave_modf_out(modf),
    .busy_out(busy), .sck_in(sck_pin), .sck_out(sck), .sck_oe_out(sck_oe), .io0_in(mosi_pin),
    .io0_out(io0), .io0_oe_out(io0_oe), .io1_in(io1), .io1_out(s_miso), .io1_oe_out(io1_oe),
    .sel_n_in(sel_n_in),
    .sel_n_out(sel_n_out), .execute_in_place_mode_in(eip), .mem_rd_req_in(mem_rd),
    .mem_wr_req_in(mem_wr), .mem_rd_ack_out(mem_ack), .mem_err_out(mem_err),
    .eip_status_rd_in(st_rd), .eip_status_reg_out(st));
  qsp_flash_model qsp_flash_model_inst (.sck_in(sck), .sel_n_in(sel_n_out[0]),
    .mosi_in(io0), .reply_in(reply), .miso_out(io1), .got_out(got));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  task check(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cycles(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  task push(input [7:0] b);
    begin
      tx_data_in = b;
      tx_wr_in = 1'h1;
      cycles(1);
      tx_wr_in = 1'h0;
      cycles(1);
    end
  endtask
  task wait_rx(input [5:0] n);
    begin
      bad = 1'h0;
      for (i = 0; i < 3000 && rx_occ !== n; i = i + 1) begin
        if (manual_sel_in && sel_n_out !== 1'h0) bad = 1'h1;
        cycles(1);
      end
      check(rx_occ, n);
    end
  endtask
  task pop(input [7:0] e);
    begin
      check(rx_data, e);
      rx_rd_in = 1'h1;
      cycles(1);
      rx_rd_in = 1'h0;
      cycles(3);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_master;
    begin
      enable_in = 1'h1;
      push(8'ha5);
      wait_rx(6'h01);
      check(sck_oe, 1'h1);
      check(got, 8'ha5);
      pop(8'h3c);
      loopback_in = 1'h1;
      push(8'h96);
      wait_rx(6'h01);
      check(io0_oe, 1'h0);
      pop(8'h96);
      loopback_in = 1'h0;
    end
  endtask
  task t_inhibit;
    begin
      inhibit_in = 1'h1;
      push(8'h5a);
      bad = 1'h0;
      repeat (200) begin
        if (sck !== 1'h0 || busy !== 1'h0) bad = 1'h1;
        cycles(1);
      end
      check(bad, 1'h0);
      check(rx_empty, 1'h1);
      check(tx_occ, 6'h01);
      inhibit_in = 1'h0;
      wait_rx(6'h01);
      check(got, 8'h5a);
      pop(8'h3c);
    end
  endtask
  task t_manual;
    begin
      manual_sel_in = 1'h1;
      cycles(3);
      push(8'h11);
      push(8'h22);
      wait_rx(6'h02);
      check(bad, 1'h0);
      check(got, 8'h22);
      pop(8'h3c);
      pop(8'h00);
      manual_sel_in = 1'h0;
    end
  endtask
  task t_faults;
    begin
      enable_in = 1'h0;
      master_in = 1'h0;
      sel_n_in = 1'h0;
      cycles(3);
      check(modf, 1'h1);
      master_in = 1'h1;
      flag_clr_in = 1'h1;
      cycles(1);
      flag_clr_in = 1'h0;
      cycles(2);
      check(modf, 1'h0);
      eip = 1'h1;
      cycles(8);
      mem_rd = 1'h1;
      cycles(1);
      mem_rd = 1'h0;
      check(mem_ack, 1'h1);
      cycles(1);
      cpha_in = 1'h1;
      mem_rd = 1'h1;
      cycles(1);
      mem_rd = 1'h0;
      check({mem_err, mem_ack}, 2'h2);
      cycles(5);
      check(st[3], 1'h1);
      mem_wr = 1'h1;
      cycles(1);
      mem_wr = 1'h0;
      check(mem_err, 1'h1);
      cycles(5);
      check(st[4], 1'h1);
      cpol_in = 1'h1;
      cycles(1);
      mem_rd = 1'h1;
      cycles(1);
      mem_rd = 1'h0;
      check({mem_err, mem_ack}, 2'h1);
      eip = 1'h0;
      cpha_in = 1'h0;
      cpol_in = 1'h0;
      cycles(8);
      st_rd = 1'h1;
      cycles(1);
      st_rd = 1'h0;
      cycles(1);
      check(st[4:2], 3'h0);
    end
  endtask
  task t_slave;
    begin
      sel_n_in = 1'h1;
      master_in = 1'h0;
      enable_in = 1'h1;
      push(8'hc3);
      sel_n_in = 1'h0;
      cycles(4);
      check(io1_oe, 1'h1);
      for (i = 0; i < 8; i = i + 1) begin
        s_mosi = s_tx[7];
        s_tx = {s_tx[6:0], 1'h0};
        miso_word = {miso_word[6:0], s_miso};
        s_sck = 1'h1;
        cycles(8);
        s_sck = 1'h0;
        cycles(8);
      end
      sel_n_in = 1'h1;
      wait_rx(6'h01);
      check(miso_word, 8'hc3);
      pop(8'h69);
    end
  endtask
  initial begin
    #(8 * 40000);
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    cycles(20);
    sys_rst_in = 1'h0;
    check(st, 5'h01);
    t_master;
    t_inhibit;
    t_manual;
    t_faults;
    t_slave;
    give_verdict;
  end
endmodule
